//--- mav_pkg.sv
// constants for the measurement average and median post-processor
package mav_pkg;
  // register byte offsets
  localparam logic [3:0] MAV_CTRL_OFS = 4'h0;
  localparam logic [3:0] MAV_STAT_OFS = 4'h4;
  localparam logic [3:0] MAV_RES_OFS = 4'h8;
  // control field positions
  localparam int MAV_CNT_LSB = 0;
  localparam int MAV_CNT_W = 8;
  localparam int MAV_MED_BIT = 8;
  localparam int MAV_FREE_BIT = 9;
  localparam int MAV_SORT_BIT = 10;
  // control reset values
  localparam logic [7:0] MAV_CNT_RST = 8'h01;
  localparam logic MAV_MED_RST = 1'b0;
  localparam logic MAV_FREE_RST = 1'b0;
  localparam logic MAV_SORT_RST = 1'b0;
  // status field positions
  localparam int MAV_ST_N_LSB = 0;
  localparam int MAV_ST_MED_LSB = 8;
  localparam int MAV_ST_BUSY_BIT = 10;
  localparam int MAV_ST_HOLD_BIT = 11;
  localparam int MAV_ST_FIN_BIT = 12;
  // result register flag
  localparam int MAV_RES_FIN_BIT = 31;
  // median group length minus one
  localparam logic [1:0] MAV_MED_LAST = 2'h2;
  typedef enum logic [1:0] {MAV_IDLE, MAV_RUN, MAV_DIV, MAV_HOLD} mav_state_e;
endpackage

//--- mav_top.sv
// measurement average and median post-processor with avalon register slave
// What this block does
// R1 - averaging count is programmable from 1 to 255 measurements per result
// R2 - count of 1 reports each measurement directly; this is the reset default
// R3 - count above one reports the arithmetic mean of that many measurements
// R4 - averaging and median act the same for value and sort bin output formats
// R5 - single shot mode shows running average, then holds final until next start
// R6 - free running mode shows only completed final averages, each held until replaced
// R7 - median mode takes three measurements and passes only the middle one
// R8 - with median and averaging, average count medians of groups of three
// R9 - software sets median selection with control bit 1 and clears it with 0
// R10 - accumulator, counter and median group clear at reset and each new cycle
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
module mav_top
  import mav_pkg::*;
#(
  parameter int DATA_W = 24
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // measurement engine
  input wire logic start_in,
  input wire logic meas_valid_in,
  input wire logic signed [DATA_W-1:0] meas_data_in,
  output logic meas_ready_out,
  // display and output path
  output logic signed [DATA_W-1:0] result_out,
  output logic result_valid_out,
  output logic result_final_out,
  output logic sort_bin_output_out
);
  localparam int ACC_W = DATA_W + MAV_CNT_W;
  localparam int DIV_LAST = ACC_W - 1;

  if (DATA_W < 2 || DATA_W > 31) begin
    $error("DATA_W must lie between 2 and 31");
  end

  function automatic logic signed [DATA_W-1:0] med3(input logic signed [DATA_W-1:0] a,
      input logic signed [DATA_W-1:0] b, input logic signed [DATA_W-1:0] c);
    logic signed [DATA_W-1:0] lo;
    logic signed [DATA_W-1:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    if (c <= lo) begin
      med3 = lo;
    end else if (c >= hi) begin
      med3 = hi;
    end else begin
      med3 = c;
    end
  endfunction

  mav_state_e state_q;
  logic ack_q, med_en_q, free_q, sort_q, neg_q, div_final_q;
  logic [7:0] cnt_q, n_q, rem_q, dvs_q, div_cnt_q;
  logic signed [ACC_W-1:0] acc_q;
  logic [1:0] med_cnt_q;
  logic signed [DATA_W-1:0] med_b0_q, med_b1_q;
  logic [ACC_W-1:0] dvd_q;

  // bus handshake: one wait cycle, then the access completes
  logic bus_req, bus_go, cfg_wr;
  assign bus_req = avs_read_in || avs_write_in;
  assign bus_go = bus_req && ack_q;
  assign avs_waitrequest_out = bus_req && !ack_q;
  assign cfg_wr = bus_go && avs_write_in && avs_address_in == MAV_CTRL_OFS;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req && !ack_q;
    end
  end

  // control register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= MAV_CNT_RST; // R2
      med_en_q <= MAV_MED_RST;
      free_q <= MAV_FREE_RST;
      sort_q <= MAV_SORT_RST;
    end else if (cfg_wr) begin
      if (avs_byteenable_in[0] && avs_writedata_in[MAV_CNT_LSB +: MAV_CNT_W] != 8'h00) begin
        cnt_q <= avs_writedata_in[MAV_CNT_LSB +: MAV_CNT_W]; // R1
      end
      if (avs_byteenable_in[1]) begin
        med_en_q <= avs_writedata_in[MAV_MED_BIT]; // R9
        free_q <= avs_writedata_in[MAV_FREE_BIT];
        sort_q <= avs_writedata_in[MAV_SORT_BIT];
      end
    end
  end
  assign sort_bin_output_out = sort_q; // R4

  // sample path and median selection
  logic take, feed, div_done, cyc_final, restart, clr;
  logic signed [DATA_W-1:0] feed_val;
  logic signed [ACC_W-1:0] acc_nx;
  assign meas_ready_out = state_q == MAV_RUN;
  assign take = meas_valid_in && meas_ready_out;
  assign feed = take && (!med_en_q || med_cnt_q == MAV_MED_LAST); // R7
  assign feed_val = med_en_q ? med3(med_b0_q, med_b1_q, meas_data_in) : meas_data_in; // R7
  assign acc_nx = acc_q + ACC_W'(feed_val);
  assign div_done = state_q == MAV_DIV && div_cnt_q == 8'(DIV_LAST);
  assign cyc_final = n_q == cnt_q;
  assign restart = (!free_q && start_in) || (free_q && state_q == MAV_IDLE);
  assign clr = cfg_wr || restart || (div_done && cyc_final && free_q); // R10

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      med_cnt_q <= 2'h0; // R10
      med_b0_q <= '0;
      med_b1_q <= '0;
    end else if (clr) begin
      med_cnt_q <= 2'h0; // R10
    end else if (take && med_en_q) begin
      if (med_cnt_q == MAV_MED_LAST) begin
        med_cnt_q <= 2'h0; // R8
      end else begin
        med_cnt_q <= med_cnt_q + 2'h1;
        if (med_cnt_q == 2'h0) begin
          med_b0_q <= meas_data_in;
        end else begin
          med_b1_q <= meas_data_in;
        end
      end
    end
  end

  // accumulator and measurement counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= '0; // R10
      n_q <= 8'h00;
    end else if (clr) begin
      acc_q <= '0; // R10
      n_q <= 8'h00;
    end else if (feed) begin
      acc_q <= acc_nx; // R3 R8
      n_q <= n_q + 8'h01;
    end
  end

  // sequencing
  logic to_div;
  assign to_div = feed && (!free_q || n_q + 8'h01 == cnt_q); // R5 R6

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= MAV_IDLE;
    end else if (cfg_wr) begin
      state_q <= MAV_IDLE;
    end else if (restart) begin
      state_q <= MAV_RUN;
    end else begin
      unique case (state_q)
        MAV_IDLE: begin
          state_q <= MAV_IDLE;
        end
        MAV_RUN: begin
          if (to_div) begin
            state_q <= MAV_DIV;
          end
        end
        MAV_DIV: begin
          if (div_done) begin
            state_q <= (cyc_final && !free_q) ? MAV_HOLD : MAV_RUN; // R5
          end
        end
        MAV_HOLD: begin
          state_q <= MAV_HOLD;
        end
      endcase
    end
  end

  // restoring divider on the magnitude of the sum
  logic [8:0] rem_sh;
  logic q_bit;
  logic [ACC_W-1:0] quo_nx;
  assign rem_sh = {rem_q, dvd_q[ACC_W-1]};
  assign q_bit = rem_sh >= {1'b0, dvs_q};
  assign quo_nx = {dvd_q[ACC_W-2:0], q_bit};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dvd_q <= '0;
      rem_q <= 8'h00;
      dvs_q <= 8'h01;
      neg_q <= 1'b0;
      div_cnt_q <= 8'h00;
    end else if (state_q == MAV_RUN && to_div) begin
      dvd_q <= acc_nx[ACC_W-1] ? ACC_W'(-acc_nx) : ACC_W'(acc_nx);
      neg_q <= acc_nx[ACC_W-1];
      dvs_q <= n_q + 8'h01; // R3
      rem_q <= 8'h00;
      div_cnt_q <= 8'h00;
    end else if (state_q == MAV_DIV) begin
      dvd_q <= quo_nx;
      rem_q <= q_bit ? 8'(rem_sh - {1'b0, dvs_q}) : rem_sh[7:0];
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // display output
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= '0;
      result_valid_out <= 1'b0;
      result_final_out <= 1'b0;
      div_final_q <= 1'b0;
    end else begin
      result_valid_out <= div_done; // R5 R6
      if (div_done) begin
        result_out <= neg_q ? -DATA_W'(quo_nx) : DATA_W'(quo_nx); // R3
        result_final_out <= cyc_final;
        div_final_q <= cyc_final;
      end else if (restart && !free_q) begin
        div_final_q <= 1'b0;
      end
    end
  end

  // register read back
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0;
    end else if (bus_req && !ack_q && avs_read_in) begin
      avs_readdata_out <= 32'h0;
      unique case (avs_address_in)
        MAV_CTRL_OFS: begin
          avs_readdata_out[MAV_CNT_LSB +: MAV_CNT_W] <= cnt_q;
          avs_readdata_out[MAV_MED_BIT] <= med_en_q;
          avs_readdata_out[MAV_FREE_BIT] <= free_q;
          avs_readdata_out[MAV_SORT_BIT] <= sort_q;
        end
        MAV_STAT_OFS: begin
          avs_readdata_out[MAV_ST_N_LSB +: 8] <= n_q;
          avs_readdata_out[MAV_ST_MED_LSB +: 2] <= med_cnt_q;
          avs_readdata_out[MAV_ST_BUSY_BIT] <= state_q == MAV_RUN || state_q == MAV_DIV;
          avs_readdata_out[MAV_ST_HOLD_BIT] <= state_q == MAV_HOLD;
          avs_readdata_out[MAV_ST_FIN_BIT] <= div_final_q;
        end
        MAV_RES_OFS: begin
          avs_readdata_out[DATA_W-1:0] <= result_out;
          avs_readdata_out[MAV_RES_FIN_BIT] <= result_final_out;
        end
        default: begin
          avs_readdata_out <= 32'h0;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence first_of_group_s;
    take && med_en_q && med_cnt_q == 2'h0 && !clr;
  endsequence

  sequence single_fed_s;
    feed && !free_q && !clr;
  endsequence

  bus_answer_a: assert property (bus_req && !ack_q |=> !avs_waitrequest_out || !bus_req)
    else $error("bus access not answered after one wait cycle");
  bus_wait_a: assert property ($rose(bus_req) |-> avs_waitrequest_out)
    else $error("bus access completed without wait cycle");
  start_clear_a: assert property (!free_q && start_in && !cfg_wr // R10
    |=> acc_q == '0 && n_q == 8'h00 && med_cnt_q == 2'h0)
    else $error("start did not clear averaging state");
  free_final_a: assert property (free_q && result_valid_out |-> result_final_out) // R6
    else $error("free running display updated before final average");
  single_update_a: assert property (single_fed_s |-> ##[1:40] result_valid_out) // R5
    else $error("running average not shown in single shot mode");
  hold_stable_a: assert property (state_q == MAV_HOLD && !start_in && !cfg_wr // R5
    |=> $stable(result_out) && !result_valid_out)
    else $error("held final average changed");
  median_wait_a: assert property (first_of_group_s |=> $stable(n_q) && med_cnt_q == 2'h1) // R7
    else $error("median group fed averaging early");
  direct_pass_a: assert property (single_fed_s ##0 (cnt_q == 8'h01 && !med_en_q) // R2
    |-> ##[1:40] (result_valid_out && result_final_out))
    else $error("count of one did not report measurement as final");
endmodule

//--- mav_eng_model.sv
// measurement engine stand-in offering queued samples with random gaps
`timescale 1ns/100ps
module mav_eng_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // sample handshake
  input wire logic ready_in,
  output logic valid_out,
  output logic signed [23:0] data_out
);
  logic signed [23:0] q[$];
  int gap;
  // ready is read at the edge itself, before that edge's register updates land
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'h0;
      data_out <= 24'h0;
      gap = 0;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'h0;
      data_out <= ~data_out;
      gap = $urandom_range(0, 2);
    end else if (!valid_out) begin
      if (gap == 0 && q.size() > 0) begin
        valid_out <= 1'h1;
        data_out <= q.pop_front();
      end else begin
        // idle data toggles so a stale sample is never mistaken for a new one
        data_out <= ~data_out;
        if (gap > 0) gap--;
      end
    end
  end
endmodule

//--- tb_top.sv
// self-checking bench for the average and median post-processor
`timescale 1ns/100ps
module tb_top;
  import mav_pkg::*;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'h0, wr = 1'h0, start = 1'h0;
  logic [31:0] wd = 32'h0, rdq, rdata;
  logic wait_r, ready, mvalid, rvalid, rfinal, sbin;
  logic signed [23:0] mdata, res;
  logic [24:0] exp_q[$];
  int error_cnt = 0, samples_checked = 0;
  mav_top #(.DATA_W(24)) DUT (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_r), .start_in(start), .meas_valid_in(mvalid), .meas_data_in(mdata),
    .meas_ready_out(ready), .result_out(res), .result_valid_out(rvalid), .result_final_out(rfinal),
    .sort_bin_output_out(sbin));
  mav_eng_model eng (.clk_in(clk_in), .rst_in(rst_in), .ready_in(ready), .valid_out(mvalid), .data_out(mdata));
  initial forever #2.5 clk_in = ~clk_in;
  task check(input string what, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one avalon access, held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ws;
    @(posedge clk_in);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    do begin
      @(posedge clk_in);
      ws = wait_r;
      rdq = rdata;
    end while (ws !== 1'h0);
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  function automatic logic signed [23:0] med3(input logic signed [23:0] a, b, c);
    logic signed [23:0] lo, hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    return (c < lo) ? lo : ((c > hi) ? hi : c);
  endfunction
  task run_set(input int cnt, input int units, input bit med, input bit free, input bit srt);
    logic signed [23:0] v[3];
    logic signed [31:0] sum;
    logic [31:0] st;
    int t;
    sum = 0;
    bus(1'h1, MAV_CTRL_OFS, {21'h0, srt, free, med, cnt[7:0]});
    if (!free) begin
      @(posedge clk_in);
      start <= 1'h1;
      @(posedge clk_in);
      start <= 1'h0;
    end
    for (int i = 0; i < units; i++) begin
      for (int k = 0; k < 3; k++) begin
        t = $urandom_range(0, 4000);
        v[k] = 24'(t - 2000);
        if (med || k == 0) eng.q.push_back(v[k]);
      end
      sum += med ? med3(v[0], v[1], v[2]) : v[0];
      if (!free || i == cnt - 1) exp_q.push_back({i == cnt - 1, 24'(sum / (i + 1))});
    end
    for (t = 0; t < 4000 && exp_q.size() > 0; t++) @(posedge clk_in);
    check("results drained", 32'h0, exp_q.size());
    check("sort bin flag", {31'h0, srt}, {31'h0, sbin});
    if (units == cnt) begin
      bus(1'h0, MAV_RES_OFS, 32'h0);
      check("result register", {8'h80, 24'(sum / cnt)}, rdq);
      st = 32'h0;
      st[MAV_ST_FIN_BIT] = 1'h1;
      st[MAV_ST_BUSY_BIT] = free;
      st[MAV_ST_HOLD_BIT] = !free;
      if (!free) st[MAV_ST_N_LSB +: 8] = cnt[7:0];
      bus(1'h0, MAV_STAT_OFS, 32'h0);
      check("status register", st, rdq);
    end
    $display("test count %0d units %0d median %0d free %0d sort %0d done", cnt, units, med, free, srt);
  endtask
  // display watcher: each update is matched against the oldest note
  always @(negedge clk_in) if (rvalid === 1'h1) begin
    if (exp_q.size() == 0) check("unexpected update", 32'h0, 32'h1);
    else check("display update", {7'h0, exp_q.pop_front()}, {7'h0, rfinal, res});
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hE4A2));
    repeat (4) @(posedge clk_in);
    rst_in <= 1'h0;
    bus(1'h0, MAV_CTRL_OFS, 32'h0);
    check("control default", 32'h1, rdq);
    bus(1'h0, 4'hC, 32'h0);
    check("unmapped read", 32'h0, rdq);
    run_set(1, 1, 1'h0, 1'h0, 1'h0);
    // a sample offered during hold must wait for the next start
    eng.q.push_back(24'h000123);
    repeat (40) @(posedge clk_in);
    check("sample held off", 32'h1, {31'h0, mvalid});
    exp_q.push_back({1'h1, 24'h000123});
    @(posedge clk_in);
    start <= 1'h1;
    @(posedge clk_in);
    start <= 1'h0;
    repeat (60) @(posedge clk_in);
    check("restart drained", 32'h0, exp_q.size());
    $display("test hold and restart done");
    run_set(3, 3, 1'h0, 1'h0, 1'h0);
    run_set(3, 1, 1'h0, 1'h0, 1'h1);
    run_set(2, 2, 1'h0, 1'h0, 1'h0);
    bus(1'h1, MAV_CTRL_OFS, 32'h0);
    bus(1'h0, MAV_CTRL_OFS, 32'h0);
    check("zero count refused", 32'h2, rdq);
    run_set(1, 1, 1'h1, 1'h0, 1'h0);
    run_set(2, 2, 1'h1, 1'h1, 1'h1);
    run_set(255, 255, 1'h0, 1'h1, 1'h0);
    report_and_stop;
  end
endmodule
